// ---- src/rsl_strap_latch.sv ----
// Configuration strap latch: captures board straps at power-on reset and
// at external pin reset, and keeps the resulting configuration state.
// Assumes straps and external_reset_n are synchronous to ref_clk, and rst
// is the internal power-on reset, asynchronous and active high.
//
// Functional notes
// RULE1 - All straps are captured after power-on reset and after pin reset; the regulator-off strap is captured at power-on only.
// RULE2 - The three address straps are stored at the end of reset, 000 open.
// RULE3 - Management frames are answered only when their address matches.
// RULE4 - The stored address is the transmit scrambler seed.
// RULE5 - Straps give addresses 0 to 7; larger ones need a software write.
// RULE6 - Software may write a new address, which is then used.
// RULE7 - Mode bits load from the mode straps on pin reset release.
// RULE8 - Soft reset keeps the mode bits and does not resample the straps.
// RULE9 - Software may write the mode bits and they take effect.
// RULE10 - Interface select latches at reset rise; low is MII, high reduced.
// RULE11 - The interface mode bit loads on pin reset release and reads back.
// RULE12 - Regulator-off is sampled at power-on; high disables the regulator.
// RULE13 - The shared pin is interrupt output or transmit-error input.
// RULE14 - Pin function select latches at power-on and pin reset release.
// RULE15 - Energy efficient mode needs the shared pin as transmit input.
// RULE16 - Strap mode codes decode through a separately supplied table.
`timescale 1ns/1ps
`include "rsl_defines.svh"

module rsl_strap_latch
   import rsl_pkg::*;
(
   // Clock and power-on reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // External reset pin
   input  wire logic         external_reset_n,
   // Strap pins
   input  rsl_straps_type    straps,
   // Register port
   input  wire logic [7:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [31:0]  reg_rdata,
   // Management frame address check
   input  wire logic         mgmt_frame_valid,
   input  wire logic [4:0]   mgmt_frame_addr,
   output logic              mgmt_addr_match,
   // Core configuration
   output rsl_cfg_type       cfg,
   output logic      [4:0]   scrambler_seed,
   output logic              regulator_enable,
   output logic              core_reset,
   output logic              soft_reset_pulse,
   output logic              energy_efficient_mode,
   // Shared interrupt / transmit-error pin
   input  wire logic         irq_request,
   input  wire logic         shared_pin_in,
   output logic              irq_out_n,
   output logic              shared_pin_oe_n,
   output logic              transmit_error_in,
   output logic              transmit_fifth_bit
);

   // Address decode, used for both reads and writes
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
      reg_hit = (a == o);
   endfunction

   rsl_cap_state_type state_reg;
   rsl_cap_state_type state_next;

   rsl_cfg_type       cfg_reg;
   rsl_cfg_type       cfg_next;
   logic [2:0]        strap_mode_reg;
   logic              regulator_off_reg;
   logic              irq_select_reg;
   logic              eee_enable_reg;
   logic              soft_reset_reg;
   logic              ext_n_reg;
   logic              load_pending_reg;
   logic [31:0]       rdata_reg;
   logic [31:0]       rdata_next;

   wire rsl_mode_type decoded_mode;
   wire logic         ext_rise;
   wire logic         capture_por;
   wire logic         capture_pin;
   wire logic         capture_any;
   wire logic         hit_ctrl;
   wire logic         hit_modes;
   wire logic         hit_status;
   wire logic         wr_ctrl;
   wire logic         wr_modes;
   wire logic         eee_allowed;
   wire logic [31:0]  ctrl_view;
   wire logic [31:0]  modes_view;
   wire logic [31:0]  status_view;

   // Rising edge of the external reset pin
   assign ext_rise = external_reset_n & ~ext_n_reg;

   // RULE1 both reset sources
   assign capture_por = (state_reg == RSL_CAP_POR);
   assign capture_pin = (state_reg == RSL_CAP_HOLD) & ext_rise;
   assign capture_any = capture_por | capture_pin;

   // Register decode
   assign hit_ctrl   = reg_hit(reg_addr, `RSL_CTRL_OFF);
   assign hit_modes  = reg_hit(reg_addr, `RSL_MODES_OFF);
   assign hit_status = reg_hit(reg_addr, `RSL_STATUS_OFF);
   assign wr_ctrl    = reg_wr & hit_ctrl;
   assign wr_modes   = reg_wr & hit_modes;

   // RULE16 strap decode
   rsl_mode_decode u_mode_decode
   (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .mode_code (straps.mode_straps),
      .mode_out  (decoded_mode)
   );

   // Capture sequencer: the strap level is taken one clock after release,
   // so an asynchronous reset never loads a pin value directly.
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         RSL_CAP_POR:
            state_next = external_reset_n ? RSL_CAP_RUN : RSL_CAP_HOLD;
         RSL_CAP_RUN:
            if (!external_reset_n)
               state_next = RSL_CAP_HOLD;
         RSL_CAP_HOLD:
            if (external_reset_n)
               state_next = RSL_CAP_RUN;
         default:
            state_next = RSL_CAP_POR;
      endcase
   end

   // Configuration next value
   always_comb
   begin
      cfg_next = cfg_reg;
      if (capture_any)
      begin
         // RULE2 address straps
         // RULE5 zero-extended 0..7
         cfg_next.station_address_field = {2'b00,
                                           straps.station_address_straps};
         // RULE10 interface latch
         // RULE11 interface mode bit
         cfg_next.interface_mode_bit = straps.reduced_interface_select;
      end
      else if (load_pending_reg)
      begin
         // RULE7 mode from straps
         cfg_next.mode = decoded_mode;
      end
      else if (wr_modes)
      begin
         // RULE6 software address
         cfg_next.station_address_field =
            reg_wdata[`RSL_MODES_ADDR_MSB:`RSL_MODES_ADDR_LSB];
         // RULE9 software mode
         cfg_next.mode =
            rsl_mode_type'(reg_wdata[`RSL_MODES_MODE_MSB:`RSL_MODES_MODE_LSB]);
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg        <= RSL_CAP_POR;
         ext_n_reg        <= 1'b0;
         load_pending_reg <= 1'b0;
      end
      else
      begin
         state_reg        <= state_next;
         ext_n_reg        <= external_reset_n;
         load_pending_reg <= capture_any;
      end
   end

   // RULE8 soft reset leaves cfg
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_reg.station_address_field <= `RSL_ADDR_RESET;
         cfg_reg.interface_mode_bit    <= 1'b0;
         cfg_reg.mode                  <= rsl_mode_type'(`RSL_MODE_RESET);
      end
      else
         cfg_reg <= cfg_next;
   end

   // Raw strap copies for status
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         strap_mode_reg <= `RSL_MODE_RESET;
      else if (capture_any)
         strap_mode_reg <= straps.mode_straps;
   end

   // RULE12 regulator at power-on only
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         regulator_off_reg <= 1'b0;
      else if (capture_por)
         regulator_off_reg <= straps.regulator_off_strap;
   end

   // RULE14 pin select latch
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         irq_select_reg <= 1'b1;
      else if (capture_any)
         irq_select_reg <= straps.irq_pin_function_select;
   end

   // Control register; soft reset bit clears itself after one cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         eee_enable_reg <= 1'b0;
         soft_reset_reg <= 1'b0;
      end
      else
      begin
         soft_reset_reg <= wr_ctrl & reg_wdata[`RSL_CTRL_SOFT_BIT];
         if (wr_ctrl)
            eee_enable_reg <= reg_wdata[`RSL_CTRL_EEE_BIT];
      end
   end

   // Register read views; unused bits read as zero
   assign ctrl_view   = {30'h0000_0000, eee_enable_reg, soft_reset_reg};
   assign modes_view  = {23'h00_0000, cfg_reg.mode,
                         cfg_reg.interface_mode_bit,
                         cfg_reg.station_address_field};
   assign status_view = {25'h000_0000, ~(state_reg == RSL_CAP_RUN),
                         eee_allowed, strap_mode_reg,
                         irq_select_reg, regulator_off_reg};

   // Read data stands only in the cycle after the strobe
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (reg_rd)
      begin
         if (hit_ctrl)
            rdata_next = ctrl_view;
         else if (hit_modes)
            rdata_next = modes_view;
         else if (hit_status)
            rdata_next = status_view;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rdata_reg <= 32'h0000_0000;
      else
         rdata_reg <= rdata_next;
   end

   assign reg_rdata = rdata_reg;

   // RULE3 frame address match
   assign mgmt_addr_match = mgmt_frame_valid &
      (mgmt_frame_addr == cfg_reg.station_address_field);

   // RULE4 scrambler seed
   assign scrambler_seed = cfg_reg.station_address_field;

   // RULE7 datapath from register
   assign cfg = cfg_reg;

   assign regulator_enable = ~regulator_off_reg;
   assign core_reset       = ~(state_reg == RSL_CAP_RUN) | load_pending_reg;
   assign soft_reset_pulse = soft_reset_reg;

   // RULE15 needs transmit mode
   // Reduced interface also rules it out, since the extra pins are absent.
   assign eee_allowed = eee_enable_reg & ~irq_select_reg &
                        ~cfg_reg.interface_mode_bit;
   assign energy_efficient_mode = eee_allowed;

   // RULE13 shared pin function
   // Open-drain style: the pin is only pulled low, never driven high.
   assign irq_out_n          = 1'b0;
   assign shared_pin_oe_n    = ~(irq_select_reg & irq_request);
   assign transmit_error_in  = ~irq_select_reg & shared_pin_in &
                               ~cfg_reg.interface_mode_bit;
   assign transmit_fifth_bit = ~irq_select_reg & shared_pin_in &
                               cfg_reg.interface_mode_bit;

endmodule

// ---- inc/rsl_defines.svh ----
// Offsets, field positions, reset values and strap table for the strap latch.
// Assumes inclusion by bare name; holds definitions only.
`ifndef RSL_DEFINES_SVH
`define RSL_DEFINES_SVH

// Register byte offsets
`define RSL_CTRL_OFF        8'h00
`define RSL_MODES_OFF       8'h04
`define RSL_STATUS_OFF      8'h08

// Control register fields
`define RSL_CTRL_SOFT_BIT   0
`define RSL_CTRL_EEE_BIT    1

// Special modes register fields
`define RSL_MODES_ADDR_LSB  0
`define RSL_MODES_ADDR_MSB  4
`define RSL_MODES_IFM_BIT   5
`define RSL_MODES_MODE_LSB  6
`define RSL_MODES_MODE_MSB  8

// Status register fields
`define RSL_STAT_REGULATOR_OFF_STRAP_BIT 0
`define RSL_STAT_IRQSEL_BIT 1
`define RSL_STAT_STRAP_LSB  2
`define RSL_STAT_STRAP_MSB  4
`define RSL_STAT_EEEOK_BIT  5
`define RSL_STAT_HOLD_BIT   6

// Reset values
`define RSL_ADDR_RESET      5'h00
`define RSL_MODE_RESET      3'h0

// Strap mode table, one 3-bit entry {autoneg,duplex,speed} per strap code,
// entry 0 in the low bits; replace with the supplied encoding table.
`define RSL_MODE_TABLE      24'h000000

`endif

// ---- inc/rsl_pkg.sv ----
// Types shared by the strap latch and its mode decoder.
// Assumes rsl_defines.svh is compiled alongside.
package rsl_pkg;

   typedef struct packed {
      logic [2:0] station_address_straps;
      logic [2:0] mode_straps;
      logic       reduced_interface_select;
      logic       regulator_off_strap;
      logic       irq_pin_function_select;
   } rsl_straps_type;

   typedef struct packed {
      logic autoneg;
      logic duplex;
      logic speed;
   } rsl_mode_type;

   typedef struct packed {
      logic [4:0]   station_address_field;
      logic         interface_mode_bit;
      rsl_mode_type mode;
   } rsl_cfg_type;

   typedef enum logic [1:0] {
      RSL_CAP_POR  = 2'b00,
      RSL_CAP_RUN  = 2'b01,
      RSL_CAP_HOLD = 2'b10
   } rsl_cap_state_type;

endpackage

// ---- src/rsl_mode_decode.sv ----
// Maps a 3-bit mode strap code onto speed, duplex and auto-negotiation.
// Assumes the encoding table arrives through TABLE; output is registered.
`timescale 1ns/1ps
`include "rsl_defines.svh"

module rsl_mode_decode
   import rsl_pkg::*;
#(
   parameter logic [23:0] TABLE = `RSL_MODE_TABLE
)
(
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // Strap code in, decoded mode out
   input  wire logic [2:0]   mode_code,
   output rsl_mode_type      mode_out
);

   wire logic [2:0] entry;

   // RULE16 table lookup
   assign entry = TABLE[{mode_code, 2'b00} - {2'b00, mode_code} +: 3];

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         mode_out <= rsl_mode_type'(`RSL_MODE_RESET);
      else
         mode_out <= rsl_mode_type'(entry);
   end

endmodule

// ---- dv/rsl_strap_latch_chk.sv ----
// Port checks for the strap latch.
// Assumes one clock, ref_clk, and rst as async active-high reset.
`timescale 1ns/1ps
`include "rsl_defines.svh"

module rsl_strap_latch_chk
   import rsl_pkg::*;
(
   // Clock and resets
   input wire logic         ref_clk,
   input wire logic         rst,
   input wire logic         external_reset_n,
   // Straps and register port
   input rsl_straps_type    straps,
   input wire logic [7:0]   reg_addr,
   input wire logic [31:0]  reg_wdata,
   input wire logic         reg_wr,
   input wire logic         reg_rd,
   input wire logic [31:0]  reg_rdata,
   // Outputs and their causes
   input wire logic         mgmt_frame_valid,
   input wire logic [4:0]   mgmt_frame_addr,
   input wire logic         mgmt_addr_match,
   input rsl_cfg_type       cfg,
   input wire logic [4:0]   scrambler_seed,
   input wire logic         regulator_enable,
   input wire logic         core_reset,
   input wire logic         soft_reset_pulse,
   input wire logic         energy_efficient_mode,
   input wire logic         irq_request,
   input wire logic         shared_pin_oe_n,
   input wire logic         transmit_fifth_bit
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_pin_release;
      !external_reset_n ##1 external_reset_n;
   endsequence
   sequence s_soft_write;
      reg_wr && reg_addr == `RSL_CTRL_OFF && reg_wdata[`RSL_CTRL_SOFT_BIT];
   endsequence

   chk_addr_capture: assert property (s_pin_release |=>
      cfg.station_address_field == {2'b00, $past(straps[8:6])})
      else $error("address not captured at pin release");
   chk_ifm_capture: assert property (s_pin_release |=>
      cfg.interface_mode_bit == $past(straps.reduced_interface_select))
      else $error("interface mode not captured at pin release");
   chk_mode_load: assert property (s_pin_release |=> ##1
      cfg.mode == rsl_mode_type'(3'h0))
      else $error("mode bits not loaded from table");
   chk_hold_core: assert property (!external_reset_n |=> core_reset)
      else $error("core not held in pin reset");
   chk_match_addr: assert property (mgmt_addr_match ==
      (mgmt_frame_valid && mgmt_frame_addr == cfg.station_address_field))
      else $error("address match wrong");
   chk_seed_addr: assert property (
      scrambler_seed == cfg.station_address_field)
      else $error("seed differs from address");
   chk_reg_por: assert property ($changed(regulator_enable)
      |-> $past(rst, 2))
      else $error("regulator changed outside power-on");
   chk_soft_pulse: assert property (s_soft_write |=>
      soft_reset_pulse ##1 !soft_reset_pulse)
      else $error("soft reset pulse wrong");
   chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   chk_eee_mii: assert property (energy_efficient_mode |->
      !cfg.interface_mode_bit && shared_pin_oe_n)
      else $error("energy mode with wrong pin use");
   chk_oe_irq: assert property (!shared_pin_oe_n |-> irq_request)
      else $error("shared pin driven without request");
   chk_fifth_route: assert property (
      transmit_fifth_bit |-> cfg.interface_mode_bit)
      else $error("fifth bit outside reduced mode");
endmodule

bind rsl_strap_latch rsl_strap_latch_chk u_chk (.ref_clk, .rst,
   .external_reset_n, .straps, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .mgmt_frame_valid, .mgmt_frame_addr, .mgmt_addr_match,
   .cfg, .scrambler_seed, .regulator_enable, .core_reset,
   .soft_reset_pulse, .energy_efficient_mode, .irq_request,
   .shared_pin_oe_n, .transmit_fifth_bit);

// ---- dv/rsl_board.sv ----
// Board model: strap resistors with internal pulls, and a pin reset source.
// Assumes the bench changes fitted straps only around a reset request.
`timescale 1ns/1ps

module rsl_board
   import rsl_pkg::*;
#(
   parameter int LOW_CYCLES = 3
)
(
   // Clock
   input  wire logic        ref_clk,
   // Bench controls
   input  rsl_straps_type   fitted,
   input  rsl_straps_type   level,
   input  wire logic        reset_req,
   // Board nets
   output rsl_straps_type   straps,
   output logic             external_reset_n
);
   localparam rsl_straps_type PULLS = 9'h001;
   int cnt = 0;
   assign straps = (fitted & level) | (~fitted & PULLS);
   initial external_reset_n = 1'b1;
   always @(posedge ref_clk)
   begin
      if (reset_req)
         cnt <= LOW_CYCLES;
      else if (cnt != 0)
         cnt <= cnt - 1;
      external_reset_n <= !(reset_req || cnt > 1);
   end
endmodule

// ---- dv/tb.sv ----
// Register-level bench for the strap latch.
// Assumes the board model owns the strap nets and the pin reset.
`timescale 1ns/1ps
`include "rsl_defines.svh"

module tb
   import rsl_pkg::*;
;
   logic            ref_clk = 1'b0;
   logic            rst = 1'b1;
   logic [7:0]      reg_addr = 8'h00;
   logic [31:0]     reg_wdata = 32'h0;
   logic            reg_wr = 1'b0;
   logic            reg_rd = 1'b0;
   logic            mgmt_frame_valid = 1'b0;
   logic [4:0]      mgmt_frame_addr = 5'h00;
   logic            irq_request = 1'b0;
   logic            shared_pin_in = 1'b0;
   logic            reset_req = 1'b0;
   rsl_straps_type  fitted = '0;
   rsl_straps_type  level = '0;
   rsl_straps_type  straps;
   rsl_cfg_type     cfg;
   logic [31:0]     reg_rdata;
   logic [4:0]      scrambler_seed;
   logic            external_reset_n;
   logic            mgmt_addr_match;
   logic            regulator_enable;
   logic            core_reset;
   logic            soft_reset_pulse;
   logic            energy_efficient_mode;
   logic            shared_pin_oe_n;
   logic            transmit_error_in;
   logic            transmit_fifth_bit;
   logic            irq_out_n;
   int              mismatches = 0;
   int              n_checks = 0;
   int              i;

   rsl_board u_rsl_board (.ref_clk, .fitted, .level, .reset_req, .straps,
      .external_reset_n);
   rsl_strap_latch u_rsl_strap_latch (.ref_clk, .rst, .external_reset_n,
      .straps, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .mgmt_frame_valid, .mgmt_frame_addr, .mgmt_addr_match, .cfg,
      .scrambler_seed, .regulator_enable, .core_reset, .soft_reset_pulse,
      .energy_efficient_mode, .irq_request, .shared_pin_in, .irq_out_n,
      .shared_pin_oe_n, .transmit_error_in, .transmit_fifth_bit);

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic chk_rd(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 cmp(what, exp, reg_rdata);
   endtask

   // Waits are bounded; a stuck reset ends the run
   task automatic pin_reset(input rsl_straps_type f, l);
      int k;
      @(posedge ref_clk);
      fitted <= f;
      level <= l;
      reset_req <= 1'b1;
      @(posedge ref_clk);
      reset_req <= 1'b0;
      #1;
      for (k = 0; k < 20 && (external_reset_n !== 1'b1
           || core_reset !== 1'b0); k++)
      begin
         @(posedge ref_clk);
         #1;
      end
      if (k == 20)
      begin
         mismatches++;
         finish_test();
      end
   endtask

   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end

   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk_rd("modes", `RSL_MODES_OFF, 32'h0);
      chk_rd("status", `RSL_STATUS_OFF, 32'h2);
      cmp("regulator", 32'h1, regulator_enable);
      $display("test power_on done");
      pin_reset(9'h1FF, 9'h1F6);
      chk_rd("modes", `RSL_MODES_OFF, 32'h27);
      chk_rd("status", `RSL_STATUS_OFF, 32'h18);
      cmp("regulator", 32'h1, regulator_enable);
      cmp("seed", 32'h7, scrambler_seed);
      for (i = 6; i < 8; i++)
      begin
         mgmt_frame_valid <= 1'b1;
         mgmt_frame_addr <= i[4:0];
         #2 cmp("match", i == 7, mgmt_addr_match);
      end
      shared_pin_in <= 1'b1;
      #2 cmp("transmit_fifth_bit", 32'h1, transmit_fifth_bit);
      cmp("transmit_error_in", 32'h0, transmit_error_in);
      cmp("irq_out_n", 32'h0, irq_out_n);
      shared_pin_in <= 1'b0;
      $display("test pin_reset done");
      wr(`RSL_MODES_OFF, 32'h15F);
      chk_rd("modes", `RSL_MODES_OFF, 32'h17F);
      cmp("mode", 32'h5, cfg.mode);
      cmp("seed", 32'h1F, scrambler_seed);
      level <= 9'h1D6;
      wr(`RSL_CTRL_OFF, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk_rd("modes", `RSL_MODES_OFF, 32'h17F);
      $display("test software done");
      pin_reset(9'h1FF, 9'h0C0);
      wr(`RSL_CTRL_OFF, 32'h2);
      chk_rd("modes", `RSL_MODES_OFF, 32'h3);
      chk_rd("status", `RSL_STATUS_OFF, 32'h20);
      shared_pin_in <= 1'b1;
      irq_request <= 1'b1;
      #2 cmp("eee", 32'h1, energy_efficient_mode);
      cmp("transmit_error_in", 32'h1, transmit_error_in);
      cmp("oe_n", 32'h1, shared_pin_oe_n);
      pin_reset(9'h000, 9'h000);
      wr(`RSL_CTRL_OFF, 32'h2);
      wr(`RSL_STATUS_OFF, 32'hFFFF);
      chk_rd("status", `RSL_STATUS_OFF, 32'h2);
      chk_rd("unmapped", 8'h0C, 32'h0);
      cmp("eee", 32'h0, energy_efficient_mode);
      cmp("oe_n", 32'h0, shared_pin_oe_n);
      cmp("transmit_error_in", 32'h0, transmit_error_in);
      $display("test pin_function done");
      finish_test();
   end
endmodule
